// ==== lane_pkg.sv ====
// Purpose: shared types, constants and lane helpers for strobe generation
// Assumes: 64-bit data bus, eight byte lanes, byte offset in addr[2:0]
// Notes:   helpers are pure functions used by planner, top and checks
package lane_pkg;

  typedef enum logic [1:0] {
    SZ_BYTE  = 2'h0,
    SZ_HALF  = 2'h1,
    SZ_WORD  = 2'h2,
    SZ_DWORD = 2'h3
  } size_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR1 = 3'h1,
    ST_ADDR2 = 3'h3,
    ST_DATA2 = 3'h2,
    ST_DATA1 = 3'h5
  } state_e;

  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  DW_BASE_OFF   = 3'h0;
  localparam logic [28:0] DW_STEP       = 29'h1;
  localparam logic [31:0] ADDR_RST      = 32'h0;
  localparam logic [63:0] DATA_RST      = 64'h0;
  localparam logic [7:0]  LANE_RST      = 8'h0;

  // strobes that size and low address imply, on a 16-lane span
  function automatic logic [15:0] span_mask(size_e sz, logic [2:0] off);
    logic [15:0] ones;
    case (sz)
      SZ_BYTE: ones = 16'h0001;
      SZ_HALF: ones = 16'h0003;
      SZ_WORD: ones = 16'h000F;
      default: ones = 16'h00FF;
    endcase
    span_mask = ones << off;
  endfunction : span_mask

  // smallest aligned power-of-two container holding lanes lo..hi
  function automatic size_e container(logic [2:0] lo, logic [2:0] hi);
    if (lo == hi)
      container = SZ_BYTE;
    else if (lo[2:1] == hi[2:1])
      container = SZ_HALF;
    else if (lo[2] == hi[2])
      container = SZ_WORD;
    else
      container = SZ_DWORD;
  endfunction : container

endpackage : lane_pkg

// ==== xfer_plan_if.sv ====
// Purpose: carries an access and its per-transfer lane plan
// Assumes: combinational planner, consumer registers the results
// Notes:   user drives offset and size, planner answers
`timescale 1ns/1ps
interface xfer_plan_if;
  logic            [2:0] off;
  lane_pkg::size_e       size;
  logic                  split;
  logic            [7:0] first_strb;
  logic            [7:0] second_strb;
  lane_pkg::size_e       first_hsize;
  lane_pkg::size_e       second_hsize;
  logic                  first_unalign;
  logic                  second_unalign;

  modport planner (input off, size, output split, first_strb, second_strb,
                   first_hsize, second_hsize, first_unalign, second_unalign);
  modport user (output off, size, input split, first_strb, second_strb,
                first_hsize, second_hsize, first_unalign, second_unalign);
endinterface : xfer_plan_if

// ==== lane_map.sv ====
// Purpose: strobes, size code and misaligned flag for both transfers
// Assumes: offset and size stable while the plan is read
// Notes:   purely combinational, no state
`timescale 1ns/1ps
module lane_map (
  xfer_plan_if.planner pl
);
  import lane_pkg::*;

  logic [15:0] span;
  logic [3:0]  last;

  always_comb begin
    span = span_mask(pl.size, pl.off);
    last = {1'b0, pl.off} + ((4'h1 << pl.size) - 4'h1);
    pl.split = last[3];
    pl.first_strb = span[7:0];
    pl.second_strb = span[15:8];
    // crossing keeps the requested size, otherwise the container
    pl.first_hsize = last[3] ? pl.size : container(pl.off, last[2:0]);
    pl.second_hsize = container(DW_BASE_OFF, last[2:0]);
    pl.first_unalign = {8'h00, span[7:0]} != span_mask(pl.first_hsize, pl.off);
    pl.second_unalign = {8'h00, span[15:8]} != span_mask(pl.second_hsize, DW_BASE_OFF);
  end

endmodule : lane_map

// ==== lane_permute.sv ====
// Purpose: endian byte routing between register image and bus lanes
// Assumes: register value is right-justified, n bytes of the access
// Notes:   same lanes for both endian modes, only byte order differs
`timescale 1ns/1ps
module lane_permute (
  input  wire logic            [2:0]  off,
  input  wire lane_pkg::size_e        size,
  input  wire logic                   big_endian,
  input  wire logic            [63:0] reg_data,
  input  wire logic            [63:0] lo_data,
  input  wire logic            [63:0] hi_data,
  output logic                 [63:0] wdata_first,
  output logic                 [63:0] wdata_second,
  output logic                 [63:0] load_data
);
  import lane_pkg::*;

  logic [3:0] n;
  assign n = 4'h1 << size;

  for (genvar i = 0; i < 8; i++) begin : g_lane
    logic [3:0] k1;
    logic [3:0] k2;
    logic [3:0] r1;
    logic [3:0] r2;
    logic [3:0] kr;
    logic [3:0] pos;
    logic [7:0] wf;
    logic [7:0] ws;
    logic [7:0] ld;
    always_comb begin
      k1 = 4'(i) - {1'b0, off};
      k2 = 4'(i + 8) - {1'b0, off};
      // big-endian: most significant byte at the lowest address
      r1 = big_endian ? n - 4'h1 - k1 : k1;
      r2 = big_endian ? n - 4'h1 - k2 : k2;
      kr = big_endian ? n - 4'h1 - 4'(i) : 4'(i);
      pos = {1'b0, off} + kr;
      // idle lanes carry zero, a defined filler only
      wf = (k1 < n) ? reg_data[8*r1[2:0] +: 8] : 8'h00;
      ws = (k2 < n) ? reg_data[8*r2[2:0] +: 8] : 8'h00;
      if (4'(i) >= n)
        ld = 8'h00;
      else if (pos[3])
        ld = hi_data[8*pos[2:0] +: 8];
      else
        ld = lo_data[8*pos[2:0] +: 8];
    end
    assign wdata_first[8*i +: 8]  = wf;
    assign wdata_second[8*i +: 8] = ws;
    assign load_data[8*i +: 8]    = ld;
  end

endmodule : lane_permute

// ==== ahb_byte_lane_strobe_gen.sv ====
// Purpose: turns load/store requests into one or two AHB-Lite transfers
// Assumes: single outstanding request, no error response handling
// Notes:   request taken only while req_ready is high
//
// Functional notes
// - eight strobes mark exactly the bytes in the current transfer.
// - aligned transfers strobe exactly the bytes of size and low address.
// - misaligned strobes may cover a subset; slave selects bytes by strobes.
// - byte offset n uses data bits 8n+7:8n and strobe n.
// - accesses crossing a doubleword become two transfers, second at offset 0.
// - first transfer of a split keeps the original address.
// - first transfer of a split keeps the requested size code.
// - unsplit misaligned access uses the smallest aligned container size.
// - strobed lanes match for both endians; bytes are permuted inside.
// - unstrobed lanes carry defined filler; receiver ignores them.
// - half at 7: lane 7 half flagged, then lane 0 byte unflagged.
// - word at 5: lanes 5-7 word flagged, then lane 0 byte unflagged.
// - dword at 3: lanes 3-7 flagged, then lanes 0-2 word flagged.
// - dword at 4: lanes 4-7 flagged, then lanes 0-3 word unflagged.
// - dword at 7: lane 7 flagged, then lanes 0-6 dword flagged.
// - stores place bytes by endianness, big-endian MSB at lowest address.
// - size code byte 00, half 01, word 10, doubleword 11.
// - misaligned flag rises when strobes differ from size and address.
`timescale 1ns/1ps
module ahb_byte_lane_strobe_gen (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            req_valid,
  input  wire logic     [31:0] req_addr,
  input  wire lane_pkg::size_e req_size,
  input  wire logic            req_write,
  input  wire logic            req_big_endian,
  input  wire logic     [63:0] req_wdata,
  output logic                 req_ready,
  output logic                 resp_valid,
  output logic          [63:0] resp_rdata,
  output logic          [31:0] haddr,
  output lane_pkg::size_e      hsize,
  output logic           [1:0] htrans,
  output logic                 hwrite,
  output logic           [7:0] hbstrb,
  output logic                 hunalign,
  output logic          [63:0] hwdata,
  input  wire logic            hready,
  input  wire logic     [63:0] hrdata
);
  import lane_pkg::*;

  state_e      state;
  state_e      next_state;
  logic [31:0] acc_addr;
  logic [31:0] next_acc_addr;
  size_e       acc_size;
  size_e       next_acc_size;
  logic        acc_be;
  logic        next_acc_be;
  logic [63:0] acc_wdata;
  logic [63:0] next_acc_wdata;
  logic        split;
  logic        next_split;
  logic [63:0] lo_reg;
  logic [63:0] next_lo_reg;
  logic        next_req_ready;
  logic        next_resp_valid;
  logic [63:0] next_resp_rdata;
  logic [31:0] next_haddr;
  size_e       next_hsize;
  logic [1:0]  next_htrans;
  logic        next_hwrite;
  logic [7:0]  next_hbstrb;
  logic        next_hunalign;
  logic [63:0] next_hwdata;

  logic [63:0] wdata_first;
  logic [63:0] wdata_second;
  logic [63:0] load_data;
  logic [63:0] lo_data;

  xfer_plan_if pl ();

  // idle plans the incoming request, later states the held one
  assign pl.off  = (state == ST_IDLE) ? req_addr[2:0] : acc_addr[2:0];
  assign pl.size = (state == ST_IDLE) ? req_size : acc_size;

  lane_map u_map (
    .pl (pl)
  );

  // an unsplit read finishes with its lanes still on hrdata
  assign lo_data = (state == ST_DATA2) ? lo_reg : hrdata;

  lane_permute u_permute (
    .off          (acc_addr[2:0]),
    .size         (acc_size),
    .big_endian   (acc_be),
    .reg_data     (acc_wdata),
    .lo_data      (lo_data),
    .hi_data      (hrdata),
    .wdata_first  (wdata_first),
    .wdata_second (wdata_second),
    .load_data    (load_data)
  );

  always_comb begin
    next_state      = state;
    next_acc_addr   = acc_addr;
    next_acc_size   = acc_size;
    next_acc_be     = acc_be;
    next_acc_wdata  = acc_wdata;
    next_split      = split;
    next_lo_reg     = lo_reg;
    next_req_ready  = req_ready;
    next_resp_valid = 1'b0;
    next_resp_rdata = resp_rdata;
    next_haddr      = haddr;
    next_hsize      = hsize;
    next_htrans     = htrans;
    next_hwrite     = hwrite;
    next_hbstrb     = hbstrb;
    next_hunalign   = hunalign;
    next_hwdata     = hwdata;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_acc_addr  = req_addr;
          next_acc_size  = req_size;
          next_acc_be    = req_big_endian;
          next_acc_wdata = req_wdata;
          next_split     = pl.split;
          next_req_ready = 1'b0;
          next_haddr     = req_addr;
          next_hsize     = pl.first_hsize;
          next_hbstrb    = pl.first_strb;
          next_hunalign  = pl.first_unalign;
          next_htrans    = HTRANS_NONSEQ;
          next_hwrite    = req_write;
          next_state     = ST_ADDR1;
        end
      end
      ST_ADDR1: begin
        if (hready) begin
          next_hwdata = wdata_first;
          if (split) begin
            // second address only once the first one is taken
            next_haddr    = {acc_addr[31:3] + DW_STEP, DW_BASE_OFF};
            next_hsize    = pl.second_hsize;
            next_hbstrb   = pl.second_strb;
            next_hunalign = pl.second_unalign;
            next_state    = ST_ADDR2;
          end else begin
            next_htrans = HTRANS_IDLE;
            next_state  = ST_DATA1;
          end
        end
      end
      ST_ADDR2: begin
        if (hready) begin
          next_lo_reg = hrdata;
          next_hwdata = wdata_second;
          next_htrans = HTRANS_IDLE;
          next_state  = ST_DATA2;
        end
      end
      ST_DATA1, ST_DATA2: begin
        if (hready) begin
          next_resp_valid = 1'b1;
          next_resp_rdata = load_data;
          next_req_ready  = 1'b1;
          next_state      = ST_IDLE;
        end
      end
      default: begin
        next_state     = ST_IDLE;
        next_htrans    = HTRANS_IDLE;
        next_req_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state      <= ST_IDLE;
      acc_addr   <= ADDR_RST;
      acc_size   <= SZ_BYTE;
      acc_be     <= 1'b0;
      acc_wdata  <= DATA_RST;
      split      <= 1'b0;
      lo_reg     <= DATA_RST;
      req_ready  <= 1'b1;
      resp_valid <= 1'b0;
      resp_rdata <= DATA_RST;
      haddr      <= ADDR_RST;
      hsize      <= SZ_BYTE;
      htrans     <= HTRANS_IDLE;
      hwrite     <= 1'b0;
      hbstrb     <= LANE_RST;
      hunalign   <= 1'b0;
      hwdata     <= DATA_RST;
    end else begin
      state      <= next_state;
      acc_addr   <= next_acc_addr;
      acc_size   <= next_acc_size;
      acc_be     <= next_acc_be;
      acc_wdata  <= next_acc_wdata;
      split      <= next_split;
      lo_reg     <= next_lo_reg;
      req_ready  <= next_req_ready;
      resp_valid <= next_resp_valid;
      resp_rdata <= next_resp_rdata;
      haddr      <= next_haddr;
      hsize      <= next_hsize;
      htrans     <= next_htrans;
      hwrite     <= next_hwrite;
      hbstrb     <= next_hbstrb;
      hunalign   <= next_hunalign;
      hwdata     <= next_hwdata;
    end
  end

  // checks, helper logic read only by them
  logic [15:0] span_acc;
  logic        aligned_acc;
  assign span_acc    = span_mask(acc_size, acc_addr[2:0]);
  // alignment mask is bytes minus one, not the lane pattern
  assign aligned_acc = (acc_addr[2:0] & 3'((4'h1 << acc_size) - 4'h1)) == 3'h0;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_strobe_nonempty: assert property (
    htrans == HTRANS_NONSEQ |-> hbstrb != 8'h00
  ) else $error("active transfer with no strobes");

  a_unalign_flag: assert property (
    htrans == HTRANS_NONSEQ |->
      hunalign == ({8'h00, hbstrb} != span_mask(hsize, haddr[2:0]))
  ) else $error("misaligned flag disagrees with strobes");

  a_aligned_exact: assert property (
    state == ST_ADDR1 && aligned_acc |->
      hsize == acc_size && !hunalign && {8'h00, hbstrb} == span_acc
  ) else $error("aligned transfer strobes wrong");

  a_first_address: assert property (
    state == ST_ADDR1 |-> haddr == acc_addr && htrans == HTRANS_NONSEQ
  ) else $error("first transfer address modified");

  a_first_size: assert property (
    state == ST_ADDR1 && split |-> hsize == acc_size && hunalign
  ) else $error("split first transfer size wrong");

  a_second_addr: assert property (
    state == ST_ADDR2 |->
      haddr == {acc_addr[31:3] + DW_STEP, DW_BASE_OFF} && hbstrb == span_acc[15:8]
  ) else $error("second transfer address or lanes wrong");

  a_second_order: assert property (
    state == ST_ADDR1 && !hready |=> state == ST_ADDR1 && $stable(haddr)
  ) else $error("address changed before acceptance");

  a_half_tail: assert property (
    state == ST_ADDR1 && acc_size == SZ_HALF && split |->
      hbstrb == 8'h80 && hsize == SZ_HALF && hunalign ##[1:300]
      (state == ST_ADDR2 && hbstrb == 8'h01 && hsize == SZ_BYTE && !hunalign)
  ) else $error("halfword split sequence wrong");

  a_word_tail: assert property (
    state == ST_ADDR2 && acc_size == SZ_WORD && acc_addr[2:0] == 3'h5 |->
      hbstrb == 8'h01 && hsize == SZ_BYTE && !hunalign
  ) else $error("word split tail wrong");

  a_dword_at3: assert property (
    state == ST_ADDR2 && acc_size == SZ_DWORD && acc_addr[2:0] == 3'h3 |->
      hbstrb == 8'h07 && hsize == SZ_WORD && hunalign
  ) else $error("doubleword at 3 tail wrong");

  a_dword_at4: assert property (
    state == ST_ADDR2 && acc_size == SZ_DWORD && acc_addr[2:0] == 3'h4 |->
      hbstrb == 8'h0F && hsize == SZ_WORD && !hunalign
  ) else $error("doubleword at 4 tail wrong");

  a_dword_at7: assert property (
    state == ST_ADDR2 && acc_size == SZ_DWORD && acc_addr[2:0] == 3'h7 |->
      hbstrb == 8'h7F && hsize == SZ_DWORD && hunalign
  ) else $error("doubleword at 7 tail wrong");

  c_split_write: cover property (state == ST_ADDR2 && hwrite && hready);
  c_split_read: cover property (state == ST_DATA2 && !hwrite && hready);
  c_inner_unalign: cover property (state == ST_ADDR1 && !split && hunalign);
  c_aligned_done: cover property (state == ST_DATA1 && hready);

endmodule : ahb_byte_lane_strobe_gen

// ==== ahb_mem_model.sv ====
// Purpose: AHB-Lite memory slave standing beside the strobe generator
// Assumes: four doublewords; after reset the byte at address a holds a
// Notes:   slow adds one wait state to every data phase
`timescale 1ns/1ps
module ahb_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [7:0]  hbstrb,
  input  wire logic [63:0] hwdata,
  output logic             hready,
  output logic      [63:0] hrdata
);
  logic [63:0] mem [4];
  logic        act;
  logic        wr;
  logic        waited;
  logic [1:0]  idx;
  logic [7:0]  strb;
  logic [7:0]  cnt;

  assign hready = !(slow && act && !waited);
  // churn outside read data so stale lanes never pass for data
  assign hrdata = (act && !wr && hready) ? mem[idx] : {8{cnt}};

  always @(posedge mclk) begin
    cnt <= rst ? 8'h00 : cnt + 8'h01;
    waited <= act && !hready;
    if (rst) begin
      act <= 1'b0;
      for (int i = 0; i < 4; i++)
        for (int j = 0; j < 8; j++)
          mem[i][8*j+:8] <= 8'(8 * i + j);
    end else if (hready) begin
      // size is ignored, only strobed lanes land
      if (act && wr)
        for (int j = 0; j < 8; j++)
          if (strb[j])
            mem[idx][8*j+:8] <= hwdata[8*j+:8];
      act  <= htrans == 2'h2;
      wr   <= hwrite;
      idx  <= haddr[4:3];
      strb <= hbstrb;
    end
  end
endmodule : ahb_mem_model

// ==== test_ahb_byte_lane_strobe_gen.sv ====
// Purpose: self-checking bench for the AHB byte-lane strobe generator
// Assumes: partner memory answers promptly or with one wait state
// Notes:   expected lane plans are worked out here from lane arithmetic
`timescale 1ns/1ps
module test_ahb_byte_lane_strobe_gen;
  import lane_pkg::*;
  logic        mclk;
  logic        rst;
  logic        slow;
  logic        req_valid;
  logic [31:0] req_addr;
  size_e       req_size;
  logic        req_write;
  logic        req_big_endian;
  logic [63:0] req_wdata;
  logic        req_ready;
  logic        resp_valid;
  logic [63:0] resp_rdata;
  logic [31:0] haddr;
  size_e       hsize;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [7:0]  hbstrb;
  logic        hunalign;
  logic [63:0] hwdata;
  logic        hready;
  logic [63:0] hrdata;
  int          err_count;
  int          samples_checked;
  int          nx;
  int          pidx;
  logic [31:0] la [4];
  logic [7:0]  lb [4];
  logic [1:0]  ls [4];
  logic        lu [4];
  logic        lh [4];
  logic        e_w;
  logic [63:0] lw [4];
  logic        pend;
  logic        hold;
  logic [31:0] hold_a;
  int          e_n;
  logic [7:0]  e_b [2];
  logic [1:0]  e_s [2];
  logic        e_u [2];

  ahb_byte_lane_strobe_gen u_dut (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_addr(req_addr),
    .req_size(req_size), .req_write(req_write), .req_big_endian(req_big_endian),
    .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .haddr(haddr), .hsize(hsize), .htrans(htrans),
    .hwrite(hwrite), .hbstrb(hbstrb), .hunalign(hunalign), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata));

  ahb_mem_model u_mem (
    .mclk(mclk), .rst(rst), .slow(slow), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hbstrb(hbstrb), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata));

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // log of accepted address phases and their write data
  always @(posedge mclk) begin
    if (hold)
      check(haddr, hold_a, "address moved while stalled");
    hold <= htrans == 2'h2 && hready !== 1'b1;
    hold_a <= haddr;
    if (hready && pend)
      lw[pidx] <= hwdata;
    pend <= pend && !hready;
    if (hready && htrans == 2'h2 && nx < 4) begin
      la[nx] <= haddr;
      lb[nx] <= hbstrb;
      ls[nx] <= hsize;
      lu[nx] <= hunalign;
      lh[nx] <= hwrite;
      pend <= hwrite;
      pidx <= nx;
      nx <= nx + 1;
    end
  end

  function automatic logic [1:0] cont(input int lo, input int hi);
    for (int k = 0; k < 4; k++)
      if ((lo >> k) == (hi >> k))
        return 2'(k);
    return 2'h3;
  endfunction : cont

  task automatic plan(input int sz, input int off);
    int nb;
    int last;
    nb = 1 << sz;
    last = off + nb - 1;
    e_n = (last > 7) ? 2 : 1;
    e_b[0] = 8'(((1 << nb) - 1) << off);
    e_s[0] = (e_n == 2 || off % nb == 0) ? 2'(sz) : cont(off, last);
    e_u[0] = (e_n == 2 || off % nb != 0);
    e_b[1] = 8'((1 << (last - 7)) - 1);
    e_s[1] = cont(0, last - 8);
    e_u[1] = ((last - 7) != (1 << e_s[1]));
  endtask : plan

  task automatic access(input logic [31:0] a, input int sz, input logic wr, input logic be,
                        input logic [63:0] wd, output logic [63:0] rd);
    int t;
    @(negedge mclk);
    req_addr = a;
    req_size = size_e'(sz);
    req_write = wr;
    req_big_endian = be;
    req_wdata = wd;
    e_w = wr;
    req_valid = 1'b1;
    nx = 0;
    t = 0;
    while (req_ready !== 1'b1 && t < 50) begin
      @(negedge mclk);
      t++;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    t = 0;
    while (resp_valid !== 1'b1 && t < 50) begin
      @(negedge mclk);
      t++;
    end
    check(resp_valid, 1'b1, "response pulse");
    rd = resp_rdata;
  endtask : access

  task automatic check_plan(input logic [31:0] a);
    check(nx, e_n, "transfer count");
    for (int t = 0; t < e_n; t++) begin
      check(la[t], t ? {a[31:3] + 29'h1, 3'h0} : a, "address");
      check(lb[t], e_b[t], "strobes");
      check(ls[t], e_s[t], "size code");
      check(lu[t], e_u[t], "misaligned flag");
      check(lh[t], e_w, "direction");
    end
  endtask : check_plan

  task automatic load_sweep;
    logic [63:0] rd;
    logic [63:0] ex;
    int          nb;
    for (int be = 0; be < 2; be++)
      for (int sz = 0; sz < 4; sz++)
        for (int off = 0; off < 8; off++) begin
          nb = 1 << sz;
          plan(sz, off);
          access(32'h8 + off, sz, 1'b0, be[0], 64'h0, rd);
          check_plan(32'h8 + off);
          ex = 64'h0;
          for (int i = 0; i < nb; i++)
            ex[8*i+:8] = 8'(8 + off + (be ? nb - 1 - i : i));
          check(rd, ex, "load data");
        end
  endtask : load_sweep

  task automatic store_case(input int sz, input int off, input logic be, input logic [63:0] wd);
    logic [7:0]  img [16];
    logic [63:0] ex;
    logic [63:0] rd;
    int          nb;
    nb = 1 << sz;
    foreach (img[k])
      img[k] = 8'h00;
    for (int i = 0; i < nb; i++)
      img[off + (be ? nb - 1 - i : i)] = wd[8*i+:8];
    plan(sz, off);
    access(32'h8 + off, sz, 1'b1, be, wd, rd);
    check_plan(32'h8 + off);
    for (int t = 0; t < e_n; t++) begin
      ex = 64'h0;
      for (int j = 0; j < 8; j++)
        if (e_b[t][j])
          ex[8*j+:8] = img[8*t+j];
      check(lw[t], ex, "write lanes");
    end
    access(32'h8 + off, sz, 1'b0, be, 64'h0, rd);
    check(rd, nb == 8 ? wd : wd & ((64'h1 << 8 * nb) - 64'h1), "read back");
  endtask : store_case

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // a full run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    slow = 1'b0;
    req_valid = 1'b0;
    req_addr = 32'h0;
    req_size = SZ_BYTE;
    req_write = 1'b0;
    req_big_endian = 1'b0;
    req_wdata = 64'h0;
    nx = 0;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    check(req_ready, 1'b1, "idle ready");
    check(htrans, HTRANS_IDLE, "idle transfer");
    check(hbstrb, 8'h00, "idle strobes");
    check(hunalign, 1'b0, "idle flag");
    load_sweep();
    slow = 1'b1;
    store_case(3, 3, 1'b1, 64'h0123456789ABCDEF);
    store_case(3, 3, 1'b0, 64'h0123456789ABCDEF);
    store_case(2, 5, 1'b1, 64'h00000000A1B2C3D4);
    store_case(1, 7, 1'b0, 64'h0000000000005AC3);
    store_case(3, 7, 1'b1, 64'hF0E1D2C3B4A59687);
    store_case(3, 4, 1'b0, 64'h1122334455667788);
    complete_run();
  end
endmodule : test_ahb_byte_lane_strobe_gen
